/* src/nfc_pkg.sv */
// shared constants, command bytes and carrier types of the nand host sequencer
package nfc_pkg;

  // clock and cycle conversion
  localparam int CLK_MHZ = 250;

  // least times round up to whole cycles; a zero time gives zero cycles
  function automatic int nsToCyc(input int ns);
    return (ns * CLK_MHZ + 999) / 1000;
  endfunction : nsToCyc

  // longest times round down
  function automatic int usToCyc(input int us);
    return us * CLK_MHZ;
  endfunction : usToCyc

  // bus strobe timing
  localparam int RD_ACCESS_NS = 35;
  localparam int RD_ACCESS_CYC = nsToCyc(RD_ACCESS_NS);
  localparam int BUS_CYCLE_NS = 50;
  localparam int BUS_CYCLE_CYC = nsToCyc(BUS_CYCLE_NS);
  localparam int WE_TO_BUSY_NS = 100;
  localparam int WE_TO_BUSY_CYC = nsToCyc(WE_TO_BUSY_NS);
  localparam int READY_TO_RE_NS = 20;
  localparam int READY_TO_RE_CYC = nsToCyc(READY_TO_RE_NS);
  localparam int WE_TO_RE_NS = 60;
  localparam int WE_TO_RE_CYC = nsToCyc(WE_TO_RE_NS);
  localparam int DESELECT_HOLD_NS = 100;
  localparam int DESELECT_HOLD_CYC = nsToCyc(DESELECT_HOLD_NS) + 1;

  // busy limits
  localparam int PAGE_LOAD_US = 10;
  localparam int PAGE_LOAD_CYC = usToCyc(PAGE_LOAD_US);
  localparam int PROG_US = 500;
  localparam int PROG_CYC = usToCyc(PROG_US);
  localparam int ERASE_MS = 3;
  localparam int ERASE_CYC = usToCyc(ERASE_MS * 1000);
  localparam int RST_READY_US = 5;
  localparam int RST_READY_CYC = usToCyc(RST_READY_US);
  localparam int RST_READ_US = 5;
  localparam int RST_PROG_US = 10;
  localparam int RST_ERASE_US = 500;
  localparam int TMR_W = 20;

  // command bytes
  localparam logic [7:0] CMD_PTR_A = 8'h00;
  localparam logic [7:0] CMD_PTR_B = 8'h01;
  localparam logic [7:0] CMD_PTR_C = 8'h50;
  localparam logic [7:0] CMD_PROG_LOAD = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hFF;

  // array geometry and marks
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int ROW_W = 15;
  localparam int COL_W = 10;
  localparam int BLK_W = 10;
  localparam int PAGE_W = 5;
  localparam int BLOCKS = 1024;
  localparam logic [COL_W-1:0] HALF_COL = 10'h100;
  localparam logic [COL_W-1:0] SPARE_COL = 10'h200;
  localparam logic [COL_W-1:0] MARK_COL = 10'h205;
  localparam int ADDR_CYCLES = 3;
  localparam int STAT_FAIL_BIT = 0;
  localparam logic [1:0] PARTIAL_MAIN_MAX = 2'h2;
  localparam logic [1:0] PARTIAL_SPARE_MAX = 2'h3;

  // data buffer
  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [2:0] {OP_READ, OP_PROG, OP_ERASE, OP_RESET, OP_SCAN, OP_RETIRE} nfc_op_t;
  typedef enum logic [2:0] {ERR_NONE, ERR_BAD_BLOCK, ERR_PARTIAL, ERR_TIMEOUT, ERR_FAIL} nfc_err_t;

  typedef struct packed {
    nfc_op_t op;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [COL_W-1:0] len;
  } nfc_req_t;

  typedef struct packed {
    logic valid;
    nfc_err_t err;
    logic marked;
  } nfc_rsp_t;

  typedef struct packed {
    logic cle;
    logic ale;
    logic ceN;
    logic weN;
    logic reN;
    logic wpN;
    logic spareOff;
    logic ioOe;
    logic [7:0] ioOut;
  } nfc_pins_t;

endpackage : nfc_pkg

/* src/nfc_fifo.sv */
// data fifo between the user ports and the flash data phase
`timescale 1ns/1ps
module nfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic [AW-1:0] next_wrPtr;
  logic [AW-1:0] next_rdPtr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign inReady = count != (AW + 1)'(DEPTH);
  assign outValid = count != '0;
  assign outData = mem[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // pointers wrap by width; depth is a power of two
  always_comb
  begin
    next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wrPtr] <= inData;
  end

endmodule : nfc_fifo

/* src/nfc_bbt.sv */
// invalid-block table, one bit per block, registered read
`timescale 1ns/1ps
module nfc_bbt #(
  parameter int ENTRIES = nfc_pkg::BLOCKS
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // single port
  input wire logic wrEn,
  input wire logic [nfc_pkg::BLK_W-1:0] addr,
  input wire logic wrBit,
  output logic rdBit
);
  import nfc_pkg::*;

  logic [ENTRIES-1:0] mark;
  logic [ENTRIES-1:0] next_mark;
  logic next_rdBit;

  always_comb
  begin
    next_mark = mark;
    if (wrEn)
      next_mark[addr] = wrBit;
    next_rdBit = mark[addr];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mark <= '0;
      rdBit <= 1'b0;
    end
    else
    begin
      mark <= next_mark;
      rdBit <= next_rdBit;
    end
  end

endmodule : nfc_bbt

/* src/nfc_host.sv */
// host-side sequencer that drives a byte-wide nand flash through its pins
// Operation
// - at most 2 main and 3 spare partial programs per page between erases (this host counts them for the last programmed page, lastRow, only)
// - end sequential read by holding select high over 100 ns
// - block invalid when column 517 of page 0 or 1 is not FFh
// - build table from factory marks, never erase them
// - avoid invalid blocks by mapping (this host does not map; it refuses them with ERR_BAD_BLOCK); block 0 is always valid
// - failed erase or program status retires the block
// - failed verify: replace block or correct with ecc
// - single-bit errors should be fixed by ecc, not retirement
`timescale 1ns/1ps
module nfc_host #(
  parameter int PROG_TIMEOUT_CYC = nfc_pkg::PROG_CYC,
  parameter int ERASE_TIMEOUT_CYC = nfc_pkg::ERASE_CYC
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // operation requests
  input wire logic reqValid,
  output logic reqReady,
  input wire nfc_pkg::nfc_req_t req,
  output nfc_pkg::nfc_rsp_t rsp,
  // program data in
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [7:0] wrData,
  // read data out
  output logic rdValid,
  input wire logic rdReady,
  output logic [7:0] rdData,
  // flash pins
  output nfc_pkg::nfc_pins_t pins,
  input wire logic [7:0] ioIn,
  input wire logic rbIn
);
  import nfc_pkg::*;

  typedef enum logic [3:0] {S_IDLE, S_LOOK, S_CHECK, S_CMD, S_ADDR, S_WDATA, S_CMD2, S_WB, S_BUSY,
    S_GAP, S_RDATA, S_STAT_CMD, S_STAT_RD, S_CEH, S_DONE} nfc_state_t;

  localparam logic [3:0] PH_SAMPLE = 4'(RD_ACCESS_CYC);
  localparam logic [3:0] PH_LAST = 4'(BUS_CYCLE_CYC - 1);

  nfc_state_t state, next_state;
  logic [3:0] phCnt, next_phCnt;
  logic [TMR_W-1:0] tmr, next_tmr;
  logic [COL_W-1:0] byteCnt, next_byteCnt;
  logic [1:0] addrIdx, next_addrIdx;
  logic ptrDone, next_ptrDone;
  nfc_req_t cur, next_cur;
  logic found, next_found;
  nfc_err_t err, next_err;
  logic [ROW_W-1:0] lastRow, next_lastRow;
  logic [1:0] mainCnt, next_mainCnt;
  logic [1:0] spareCnt, next_spareCnt;
  nfc_pins_t next_pins;
  nfc_rsp_t next_rsp;
  logic next_reqReady;

  logic fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
  logic [7:0] fifoInData, fifoOutData;
  logic tblWe, tblWd, tblRd;
  logic reading, progActive, readPush, progPop, isSpare, blockBad, partialOver;
  logic wrStrobe, rdStrobe, go, lowNext, strobeEnd, sampleNow;
  logic [TMR_W-1:0] busyLimit;

  function automatic logic [7:0] ptrCmd(input logic [COL_W-1:0] col);
    if (col >= SPARE_COL)
      return CMD_PTR_C;
    else if (col >= HALF_COL)
      return CMD_PTR_B;
    return CMD_PTR_A;
  endfunction : ptrCmd

  // shared buffer: read data fills it, program data drains it
  assign reading = cur.op == OP_READ && !reqReady;
  assign progActive = cur.op == OP_PROG && !reqReady;
  assign fifoInValid = reading ? readPush : wrValid;
  assign fifoInData = reading ? ioIn : wrData;
  assign wrReady = fifoInReady && !reading;
  assign fifoOutReady = progActive ? progPop : rdReady;
  assign rdValid = fifoOutValid && !progActive;
  assign rdData = fifoOutData;

  nfc_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) dataFifo (
    .mclk(mclk),
    .rst(rst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  nfc_bbt #(.ENTRIES(BLOCKS)) blockTable (
    .mclk(mclk),
    .rst(rst),
    .wrEn(tblWe),
    .addr(cur.row[ROW_W-1:PAGE_W]),
    .wrBit(tblWd),
    .rdBit(tblRd)
  );

  assign isSpare = cur.col >= SPARE_COL;
  assign blockBad = tblRd && cur.row[ROW_W-1:PAGE_W] != '0;
  assign partialOver = cur.row == lastRow && (isSpare ? spareCnt >= PARTIAL_SPARE_MAX : mainCnt >= PARTIAL_MAIN_MAX);
  assign wrStrobe = state inside {S_CMD, S_ADDR, S_WDATA, S_CMD2, S_STAT_CMD};
  assign rdStrobe = state inside {S_RDATA, S_STAT_RD};
  assign go = state == S_WDATA ? fifoOutValid : (state == S_RDATA ? cur.op == OP_SCAN || fifoInReady : 1'b1);
  assign lowNext = (wrStrobe || rdStrobe) && ((phCnt == '0 && go) || (phCnt != '0 && phCnt < PH_SAMPLE));
  assign strobeEnd = (wrStrobe || rdStrobe) && phCnt == PH_LAST;
  assign sampleNow = rdStrobe && phCnt == PH_SAMPLE;
  assign readPush = sampleNow && state == S_RDATA && cur.op == OP_READ;
  assign progPop = state == S_WDATA && phCnt == '0 && fifoOutValid;
  assign tblWe = state == S_DONE && (cur.op == OP_SCAN || cur.op == OP_RETIRE || err == ERR_FAIL);
  assign tblWd = cur.op == OP_SCAN ? found : 1'b1;

  always_comb
  begin
    case (cur.op)
      OP_READ, OP_SCAN: busyLimit = TMR_W'(PAGE_LOAD_CYC);
      OP_PROG: busyLimit = TMR_W'(PROG_TIMEOUT_CYC);
      OP_ERASE: busyLimit = TMR_W'(ERASE_TIMEOUT_CYC);
      default: busyLimit = TMR_W'(RST_READY_CYC);
    endcase
  end

  always_comb
  begin
    next_state = state;
    next_byteCnt = byteCnt;
    next_addrIdx = addrIdx;
    next_ptrDone = ptrDone;
    next_cur = cur;
    next_found = found;
    next_err = err;
    next_lastRow = lastRow;
    next_mainCnt = mainCnt;
    next_spareCnt = spareCnt;
    next_reqReady = reqReady;
    next_rsp = rsp;
    next_rsp.valid = 1'b0;
    next_pins = pins;
    next_phCnt = '0;
    if ((wrStrobe || rdStrobe) && (phCnt != '0 || go))
      next_phCnt = strobeEnd ? 4'h0 : phCnt + 4'h1;
    case (state)
      S_IDLE:
      begin
        if (reqValid && reqReady)
        begin
          next_cur = req;
          next_reqReady = 1'b0;
          next_err = ERR_NONE;
          next_found = 1'b0;
          next_ptrDone = 1'b0;
          next_byteCnt = '0;
          if (req.op == OP_SCAN)
          begin
            next_cur.row[PAGE_W-1:0] = '0;
            next_cur.col = MARK_COL;
            next_cur.len = 10'h001;
          end
          next_state = req.op == OP_RETIRE ? S_DONE : S_LOOK;
        end
      end
      S_LOOK: next_state = S_CHECK;
      S_CHECK:
      begin
        next_state = S_CMD;
        if (cur.op != OP_RESET && cur.op != OP_SCAN && blockBad)
        begin
          next_err = ERR_BAD_BLOCK;
          next_state = S_DONE;
        end
        else if (cur.op == OP_PROG && partialOver)
        begin
          next_err = ERR_PARTIAL;
          next_state = S_DONE;
        end
        else if (cur.op == OP_PROG)
        begin
          next_lastRow = cur.row;
          next_mainCnt = (cur.row == lastRow ? mainCnt : 2'h0) + {1'b0, !isSpare};
          next_spareCnt = (cur.row == lastRow ? spareCnt : 2'h0) + {1'b0, isSpare};
        end
        else if (cur.op == OP_ERASE && cur.row[ROW_W-1:PAGE_W] == lastRow[ROW_W-1:PAGE_W])
        begin
          next_mainCnt = 2'h0;
          next_spareCnt = 2'h0;
        end
      end
      S_CMD:
      begin
        case (cur.op)
          OP_PROG: next_pins.ioOut = ptrDone ? CMD_PROG_LOAD : ptrCmd(cur.col);
          OP_ERASE: next_pins.ioOut = CMD_ERASE_SETUP;
          OP_RESET: next_pins.ioOut = CMD_RESET;
          default: next_pins.ioOut = ptrCmd(cur.col);
        endcase
        if (strobeEnd)
        begin
          next_addrIdx = 2'h0;
          if (cur.op == OP_PROG && !ptrDone)
            next_ptrDone = 1'b1;
          else
            next_state = cur.op == OP_RESET ? S_WB : S_ADDR;
        end
      end
      S_ADDR:
      begin
        case (addrIdx)
          2'h0: next_pins.ioOut = isSpare ? {4'h0, cur.col[3:0]} : cur.col[7:0];
          2'h1: next_pins.ioOut = cur.row[7:0];
          default: next_pins.ioOut = {1'b0, cur.row[ROW_W-1:8]};
        endcase
        if (strobeEnd)
        begin
          next_addrIdx = addrIdx + 2'h1;
          if (addrIdx == 2'(ADDR_CYCLES - 1))
            next_state = cur.op == OP_PROG ? S_WDATA : (cur.op == OP_ERASE ? S_CMD2 : S_WB);
        end
      end
      S_WDATA:
      begin
        if (progPop)
          next_pins.ioOut = fifoOutData;
        if (strobeEnd)
        begin
          next_byteCnt = byteCnt + 10'h001;
          if (byteCnt + 10'h001 >= cur.len)
            next_state = S_CMD2;
        end
      end
      S_CMD2:
      begin
        next_pins.ioOut = cur.op == OP_PROG ? CMD_PROG_GO : CMD_ERASE_GO;
        if (strobeEnd)
          next_state = S_WB;
      end
      S_WB:
        if (tmr == TMR_W'(WE_TO_BUSY_CYC - 1))
          next_state = S_BUSY;
      S_BUSY:
      begin
        if (rbIn)
          next_state = cur.op == OP_RESET ? S_CEH : (cur.op inside {OP_PROG, OP_ERASE} ? S_STAT_CMD : S_GAP);
        else if (tmr >= busyLimit)
        begin
          next_err = ERR_TIMEOUT;
          next_state = S_CEH;
        end
      end
      S_GAP:
      begin
        if (cur.op inside {OP_READ, OP_SCAN})
        begin
          if (tmr == TMR_W'(READY_TO_RE_CYC - 1))
            next_state = S_RDATA;
        end
        else if (tmr == TMR_W'(WE_TO_RE_CYC - 1))
          next_state = S_STAT_RD;
      end
      S_RDATA:
      begin
        if (sampleNow && cur.op == OP_SCAN && ioIn != ERASED_BYTE)
          next_found = 1'b1;
        if (strobeEnd)
        begin
          next_byteCnt = byteCnt + 10'h001;
          if (byteCnt + 10'h001 >= cur.len)
            next_state = S_CEH;
        end
      end
      S_STAT_CMD:
      begin
        next_pins.ioOut = CMD_STATUS;
        if (strobeEnd)
          next_state = S_GAP;
      end
      S_STAT_RD:
      begin
        if (sampleNow && ioIn[STAT_FAIL_BIT])
          next_err = ERR_FAIL;
        if (strobeEnd)
          next_state = S_CEH;
      end
      S_CEH:
      begin
        if (tmr == TMR_W'(DESELECT_HOLD_CYC - 1))
        begin
          next_state = S_DONE;
          if (cur.op == OP_SCAN && !found && !cur.row[0] && err == ERR_NONE)
          begin
            next_cur.row[0] = 1'b1;
            next_byteCnt = '0;
            next_state = S_CMD;
          end
        end
      end
      S_DONE:
      begin
        next_rsp.valid = 1'b1;
        next_rsp.err = err;
        next_rsp.marked = tblWe && tblWd;
        next_reqReady = 1'b1;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
    next_tmr = next_state != state ? '0 : tmr + 1'b1;
    next_pins.ceN = state inside {S_IDLE, S_LOOK, S_CHECK, S_CEH, S_DONE};
    next_pins.cle = state inside {S_CMD, S_CMD2, S_STAT_CMD};
    next_pins.ale = state == S_ADDR;
    next_pins.weN = !(wrStrobe && lowNext);
    next_pins.reN = !(rdStrobe && lowNext);
    next_pins.ioOe = wrStrobe;
    next_pins.wpN = cur.op inside {OP_PROG, OP_ERASE} && !(state inside {S_IDLE, S_LOOK, S_CHECK, S_DONE});
    next_pins.spareOff = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= S_IDLE;
      phCnt <= '0;
      tmr <= '0;
      byteCnt <= '0;
      addrIdx <= '0;
      ptrDone <= 1'b0;
      cur <= '0;
      found <= 1'b0;
      err <= ERR_NONE;
      lastRow <= '0;
      mainCnt <= '0;
      spareCnt <= '0;
      pins <= '{cle: 1'b0, ale: 1'b0, ceN: 1'b1, weN: 1'b1, reN: 1'b1, wpN: 1'b0, spareOff: 1'b0, ioOe: 1'b0,
        ioOut: 8'h00};
      rsp <= '0;
      reqReady <= 1'b1;
    end
    else
    begin
      state <= next_state;
      phCnt <= next_phCnt;
      tmr <= next_tmr;
      byteCnt <= next_byteCnt;
      addrIdx <= next_addrIdx;
      ptrDone <= next_ptrDone;
      cur <= next_cur;
      found <= next_found;
      err <= next_err;
      lastRow <= next_lastRow;
      mainCnt <= next_mainCnt;
      spareCnt <= next_spareCnt;
      pins <= next_pins;
      rsp <= next_rsp;
      reqReady <= next_reqReady;
    end
  end

  // helpers for the checks below
  logic [7:0] ceHighCnt;
  logic [2:0] aleRises;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ceHighCnt <= 8'hFF;
      aleRises <= 3'h0;
    end
    else
    begin
      ceHighCnt <= !pins.ceN ? 8'h00 : (ceHighCnt == 8'hFF ? ceHighCnt : ceHighCnt + 8'h01);
      if (state == S_IDLE || state == S_CEH)
        aleRises <= 3'h0;
      else if (pins.ale && !pins.weN && next_pins.weN)
        aleRises <= aleRises + 3'h1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  partial_limit_a:
    assert property (pins.cle && $rose(pins.weN) && pins.ioOut == CMD_PROG_GO |-> mainCnt <= 2'h2 && spareCnt <= 2'h3)
      else $error("partial program count over limit");
  ceh_hold_a:
    assert property ($fell(pins.ceN) |-> ceHighCnt >= 8'(DESELECT_HOLD_CYC))
      else $error("select high hold too short");
  mark_scan_a:
    assert property (state == S_RDATA && cur.op == OP_SCAN && sampleNow && ioIn != ERASED_BYTE
      |-> ##[1:60] (tblWe && tblWd))
      else $error("factory mark not recorded");
  mark_keep_a:
    assert property (pins.cle && $rose(pins.weN) && pins.ioOut == CMD_ERASE_GO |-> !tblRd || cur.row[14:5] == '0)
      else $error("erase issued to marked block");
  bad_skip_a:
    assert property ($rose(pins.ale) && cur.op inside {OP_READ, OP_PROG} |-> !blockBad)
      else $error("access issued to invalid block");
  retire_fail_a:
    assert property (state == S_STAT_RD && sampleNow && ioIn[STAT_FAIL_BIT] |-> ##[1:60] (tblWe && tblWd))
      else $error("failed block not retired");
  retire_op_a:
    assert property (state == S_IDLE && reqValid && reqReady && req.op == OP_RETIRE |-> ##1 (tblWe && tblWd) ##1 rsp.valid)
      else $error("retire request not applied");
  no_auto_retire_a:
    assert property (tblWe |-> cur.op != OP_READ)
      else $error("read retired a block");
  addr_three_a:
    assert property (state == S_WB && $past(state) != S_WB && cur.op != OP_RESET |-> aleRises == 3'h3)
      else $error("address cycle count wrong");

  read_done_c: cover property (rsp.valid && cur.op == OP_READ && rsp.err == ERR_NONE);
  prog_done_c: cover property (rsp.valid && cur.op == OP_PROG && rsp.err == ERR_NONE);
  erase_fail_c: cover property (rsp.valid && cur.op == OP_ERASE && rsp.err == ERR_FAIL);
  scan_mark_c: cover property (rsp.valid && cur.op == OP_SCAN && rsp.marked);

endmodule : nfc_host

/* verif/nfc_flash_model.sv */
// behavioural byte-wide nand device facing the host sequencer
`timescale 1ns/1ps
module nfc_flash_model #(
  parameter int LOAD_CYC = 40,
  parameter int PROG_BUSY = 60,
  parameter int ERASE_BUSY = 80,
  parameter int FAIL_BLK = 5,
  parameter int MARK_BLK = 3
)
(
  // clock
  input wire logic mclk,
  // pins
  input wire nfc_pkg::nfc_pins_t pins,
  output logic [7:0] ioIn,
  output logic rbIn
);
  import nfc_pkg::*;
  logic [7:0] mem [int];
  logic [7:0] cmd, stat, q;
  logic weQ, reQ;
  int base, col, row, acnt, busy, blk;
  initial
  begin
    mem[MARK_BLK * 32 * 528 + 517] = 8'h00;
    {weQ, reQ, q, ioIn} = {2'b11, 8'h5A, 8'hA5};
    {cmd, stat, busy, acnt, base, col, row} = '0;
  end
  always @(posedge mclk)
  begin
    if (busy > 0) busy--;
    if (!pins.ceN && pins.weN && !weQ && pins.ioOe)
    begin
      if (pins.cle)
      begin
        cmd = pins.ioOut;
        acnt = 0;
        if (cmd == CMD_PTR_A) base = 0;
        if (cmd == CMD_PTR_B) base = 256;
        if (cmd == CMD_PTR_C) base = 512;
        if (cmd == CMD_RESET) busy = 20;
        if (cmd == CMD_PROG_GO && pins.wpN) {stat, busy} = {8'h00, PROG_BUSY};
        if (cmd == CMD_ERASE_GO && pins.wpN)
        begin
          blk = row / 32;
          stat = {7'h00, blk == FAIL_BLK};
          busy = ERASE_BUSY;
          for (int k = blk * 16896; k < (blk + 1) * 16896 && blk != FAIL_BLK; k++)
            if (mem.exists(k)) mem.delete(k);
        end
      end
      else if (pins.ale)
      begin
        if (acnt == 0) col = base + ((base == 512) ? int'(pins.ioOut[3:0]) : int'(pins.ioOut));
        if (acnt == 1) row = pins.ioOut;
        if (acnt == 2) row = row + 256 * pins.ioOut;
        acnt++;
        if (acnt == 3 && (cmd == CMD_PTR_A || cmd == CMD_PTR_B || cmd == CMD_PTR_C)) busy = LOAD_CYC;
      end
      else if (cmd == CMD_PROG_LOAD)
      begin
        mem[row * 528 + col] = (mem.exists(row * 528 + col) ? mem[row * 528 + col] : 8'hFF) & pins.ioOut;
        col++;
      end
    end
    if (!pins.ceN && !pins.reN && reQ)
    begin
      q = (cmd == CMD_STATUS) ? stat : (mem.exists(row * 528 + col) ? mem[row * 528 + col] : 8'hFF);
      col++;
      if (col == (pins.spareOff ? 512 : 528))
      begin
        busy = LOAD_CYC;
        row++;
        col = 0;
      end
    end
    // deselect ends a page load only; program and erase keep busy
    if (pins.ceN && (cmd == CMD_PTR_A || cmd == CMD_PTR_B || cmd == CMD_PTR_C)) busy = 0;
    ioIn <= (!pins.ceN && !pins.reN) ? q : ~q;
    // pull-up wire, low only while busy; registered so the host never races it
    rbIn <= (busy == 0);
    weQ = pins.weN;
    reQ = pins.reN;
  end
endmodule : nfc_flash_model

/* verif/nfc_host_tb.sv */
// self-checking bench for the nand host sequencer
`timescale 1ns/1ps
module nfc_host_tb;
  import nfc_pkg::*;
  logic mclk, rst, reqValid, reqReady, wrValid, wrReady, rdValid, rdReady, rbIn;
  logic [7:0] wrData, rdData, ioIn;
  nfc_req_t req;
  nfc_rsp_t rsp, got;
  nfc_pins_t pins;
  int fail_count, compares;
  nfc_host #(.PROG_TIMEOUT_CYC(200), .ERASE_TIMEOUT_CYC(200)) u_dut (.mclk(mclk), .rst(rst), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .rsp(rsp), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData),
    .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData), .pins(pins), .ioIn(ioIn), .rbIn(rbIn));
  nfc_flash_model u_flash (.mclk(mclk), .pins(pins), .ioIn(ioIn), .rbIn(rbIn));
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic chkErr(input string what, input nfc_err_t exp, input nfc_err_t seen);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %s seen %s", what, exp.name(), seen.name());
    end
  endtask : chkErr
  task automatic step;
    @(posedge mclk);
    #1;
  endtask : step
  task automatic op(input nfc_op_t o, input int row, input int col, input int len);
    logic ok;
    int n;
    req = '{o, ROW_W'(row), COL_W'(col), COL_W'(len)};
    reqValid = 1'b1;
    do
    begin
      ok = reqReady;
      step();
    end while (ok !== 1'b1);
    reqValid = 1'b0;
    n = 0;
    while (rsp.valid !== 1'b1 && n < 30000)
    begin
      step();
      n++;
    end
    got = rsp;
    chk("answer", 8'h01, {7'h00, rsp.valid});
  endtask : op
  // caller holds wrValid high around a run of pushes
  task automatic push(input logic [7:0] b);
    logic ok;
    wrData = b;
    do
    begin
      ok = wrReady;
      step();
    end while (ok !== 1'b1);
  endtask : push
  // caller holds rdReady high around a run of pops
  task automatic pop(input string what, input logic [7:0] exp);
    logic ok;
    logic [7:0] d;
    do
    begin
      ok = rdValid;
      d = rdData;
      step();
    end while (ok !== 1'b1);
    chk(what, exp, d);
  endtask : pop
  task automatic t_reset;
    chk("reqReady", 8'h01, {7'h00, reqReady});
    chk("ceN", 8'h01, {7'h00, pins.ceN});
    chk("wpN", 8'h00, {7'h00, pins.wpN});
    chk("rdValid", 8'h00, {7'h00, rdValid});
  endtask : t_reset
  task automatic t_scan;
    op(OP_SCAN, 3 * 32, 0, 0);
    chk("scan marked", 8'h01, {7'h00, got.marked});
    op(OP_SCAN, 2 * 32, 0, 0);
    chk("scan clean", 8'h00, {7'h00, got.marked});
    op(OP_READ, 3 * 32, 0, 1);
    chkErr("marked read", ERR_BAD_BLOCK, got.err);
  endtask : t_scan
  task automatic t_stream;
    wrValid = 1'b1;
    for (int i = 0; i < 16; i++) push(8'h10 + 8'(i));
    chk("fifo full", 8'h00, {7'h00, wrReady});
    wrValid = 1'b0;
    op(OP_PROG, 64, 0, 16);
    chkErr("program", ERR_NONE, got.err);
    op(OP_READ, 64, 0, 16);
    chkErr("read", ERR_NONE, got.err);
    rdReady = 1'b1;
    for (int i = 0; i < 16; i++) pop("read byte", 8'h10 + 8'(i));
    rdReady = 1'b0;
    chk("fifo empty", 8'h00, {7'h00, rdValid});
  endtask : t_stream
  task automatic t_partial;
    wrValid = 1'b1;
    push(8'hA5);
    wrValid = 1'b0;
    op(OP_PROG, 64, 100, 1);
    chkErr("second partial", ERR_NONE, got.err);
    op(OP_PROG, 64, 200, 1);
    chkErr("third partial", ERR_PARTIAL, got.err);
    op(OP_READ, 64, 100, 1);
    rdReady = 1'b1;
    pop("partial byte", 8'hA5);
    rdReady = 1'b0;
  endtask : t_partial
  task automatic t_erase;
    op(OP_ERASE, 64, 0, 0);
    chkErr("erase", ERR_NONE, got.err);
    op(OP_READ, 64, 517, 1);
    rdReady = 1'b1;
    pop("spare byte", 8'hFF);
    rdReady = 1'b0;
    op(OP_ERASE, 5 * 32, 0, 0);
    chkErr("erase fail", ERR_FAIL, got.err);
    chk("fail marked", 8'h01, {7'h00, got.marked});
    op(OP_RETIRE, 7 * 32, 0, 0);
    chk("retire marked", 8'h01, {7'h00, got.marked});
    op(OP_PROG, 7 * 32, 0, 1);
    chkErr("retired prog", ERR_BAD_BLOCK, got.err);
    op(OP_RESET, 0, 0, 0);
    chkErr("reset", ERR_NONE, got.err);
  endtask : t_erase
  initial
  begin
    #(4 * 80000);
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    {rst, reqValid, wrValid, rdReady, wrData} = {1'b1, 3'b000, 8'h00};
    {req, fail_count, compares} = '0;
    repeat (16) @(posedge mclk);
    #1 rst = 1'b0;
    step();
    t_reset();
    t_scan();
    t_stream();
    t_partial();
    t_erase();
    report_and_stop();
  end
endmodule : nfc_host_tb
